// [rtl/pulse_division_ten_bit_pwm.sv]
/*
  Two-channel 10-bit pulse-division PWM with byte register port.
  Below duty 3fc each period is four sub-pulses whose summed high time follows the duty.
  Assumes RUN and EVENT_PWM come from logic on CLK; software keeps byte
  accesses and writes the lower duty byte before the upper one.
*/
`timescale 1ns/1ps
`default_nettype none

module pulse_division_ten_bit_pwm
  import pwm_pkg::*;
#(
  parameter bit HAS_FORMAT_SELECT = 1'b1
)
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic RUN,
  input wire logic [1:0] EVENT_PWM,
  output logic CHANNEL_ONE_OUTPUT,
  output logic CHANNEL_TWO_OUTPUT
);

  bus_req_type req;
  ctrl_type ctrl_q;
  logic fmt_event;
  logic tick;
  logic first_half;
  logic boundary;
  logic [PHASE_BITS-1:0] phase_q;
  logic [7:0] rdata_q;
  logic [7:0] read_d;
  logic [7:0] lower_q [2];
  logic [9:0] staged_q [2];
  logic [9:0] active_q [2];
  logic [1:0] pending_q;
  logic [1:0] out_q;
  logic [1:0] odd_q;
  logic [1:0] odd_seen_q;
  logic [1:0] pin;

  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  function automatic logic hit_f(input bus_req_type r, input logic [2:0] ofs, input logic is_wr);
    hit_f = (r.addr == ofs) && (is_wr ? r.wr : r.rd);
  endfunction

  function automatic logic [2:0] lower_ofs_f(input int ch);
    lower_ofs_f = DUTY_LOWER_OFS + DUTY_STRIDE * ch[2:0];
  endfunction

  function automatic logic [2:0] upper_ofs_f(input int ch);
    upper_ofs_f = DUTY_UPPER_OFS + DUTY_STRIDE * ch[2:0];
  endfunction

  // event format only on the variant with the bit
  assign fmt_event = HAS_FORMAT_SELECT && ctrl_q.fmt;

  // control register; only live bits are stored
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ctrl_q <= '{fmt: CTRL_FMT_RESET, sel: CTRL_SEL_RESET};
    end else if (hit_f(req, CTRL_OFS, 1'b1)) begin
      ctrl_q.sel <= clk_sel_type'(req.wdata[SEL_LSB+1:SEL_LSB]);
      ctrl_q.fmt <= HAS_FORMAT_SELECT ? req.wdata[FMT_BIT] : CTRL_FMT_RESET;
    end
  end

  // RUN low (low-power modes) freezes the timebase, registers kept
  pwm_prescaler prescaler_i (
    .clk(CLK),
    .rstn(RSTN),
    .sel(ctrl_q.sel),
    .run(RUN),
    .tick(tick),
    .first_half(first_half)
  );

  assign boundary = tick && (phase_q == PHASE_LAST);

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      phase_q <= '0;
    end else if (tick) begin
      phase_q <= phase_q + 9'h001;
    end
  end

  // read path: data stands in the cycle after the strobe only
  always_comb begin
    read_d = READ_UNMAPPED;
    case (req.addr)
      CTRL_OFS: read_d = {5'b11111, HAS_FORMAT_SELECT ? ctrl_q.fmt : 1'b1, ctrl_q.sel};
      STATUS_OFS: read_d = {4'h0, out_q, pending_q};
      lower_ofs_f(0), upper_ofs_f(0), lower_ofs_f(1), upper_ofs_f(1): read_d = READ_ALL_ONES;
      default: read_d = READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      rdata_q <= READ_UNMAPPED;
    end else begin
      rdata_q <= req.rd ? read_d : READ_UNMAPPED;
    end
  end

  assign RDATA = rdata_q;

  // one generator per channel on a shared timebase
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      logic [10:0] total;
      logic [8:0] base;
      logic [1:0] rem;
      logic [8:0] width;
      logic [7:0] pos;
      logic force_high;
      logic full_slot;
      logic odd_slot;
      logic out_d;

      // each byte is its own register, word access is not decoded
      // lower byte staged alone, upper two bits join it
      always_ff @(posedge CLK) begin
        if (!RSTN) begin
          lower_q[ch] <= DUTY_LOWER_RESET;
          staged_q[ch] <= {DUTY_UPPER_RESET, DUTY_LOWER_RESET};
        end else begin
          if (hit_f(req, lower_ofs_f(ch), 1'b1)) begin
            lower_q[ch] <= req.wdata;
          end
          if (hit_f(req, upper_ofs_f(ch), 1'b1)) begin
            staged_q[ch] <= {req.wdata[1:0], lower_q[ch]};
          end
        end
      end

      // upper write arms a load taken at the period boundary
      // a write in the boundary cycle wins so that value is not lost
      always_ff @(posedge CLK) begin
        if (!RSTN) begin
          pending_q[ch] <= 1'b0;
          active_q[ch] <= {DUTY_UPPER_RESET, DUTY_LOWER_RESET};
        end else begin
          if (boundary && pending_q[ch]) begin
            active_q[ch] <= staged_q[ch];
          end
          if (hit_f(req, upper_ofs_f(ch), 1'b1)) begin
            pending_q[ch] <= 1'b1;
          end else if (boundary) begin
            pending_q[ch] <= 1'b0;
          end
        end
      end

      // total in half slots is duty + 4
      assign total = {1'b0, active_q[ch]} + DUTY_OFFSET;
      // equal share, remainder one half slot each to first pulses
      assign base = total[10:2];
      assign rem = total[1:0];
      // phase bits 8:7 pick one of four sub-pulses
      assign width = base + {8'h00, (phase_q[8:7] < rem)};
      assign pos = {1'b0, phase_q[6:0]};
      assign full_slot = pos < width[8:1];
      assign odd_slot = width[0] && (pos == width[8:1]);
      assign force_high = active_q[ch] >= FULL_HIGH_MIN;

      // for /2 and up the half slot is the prescaler's first half
      always_comb begin
        if (fmt_event) begin
          out_d = EVENT_PWM[ch];
        end else begin
          out_d = force_high || full_slot || (odd_slot && ctrl_q.sel != DIV_1 && first_half);
        end
      end

      always_ff @(posedge CLK) begin
        if (!RSTN) begin
          out_q[ch] <= 1'b0;
          odd_q[ch] <= 1'b0;
        end else if (RUN) begin
          out_q[ch] <= out_d;
          odd_q[ch] <= odd_slot && ctrl_q.sel == DIV_1 && !force_high && !fmt_event;
        end
      end

      // at phi the half step needs the falling edge; the pin is the
      // OR of flops so it stays glitch-free, traded for a negedge stage
      always_ff @(negedge CLK) begin
        if (!RSTN) begin
          odd_seen_q[ch] <= 1'b0;
        end else begin
          odd_seen_q[ch] <= odd_q[ch];
        end
      end

      assign pin[ch] = out_q[ch] || (odd_q[ch] && !odd_seen_q[ch]);
    end
  endgenerate

  assign CHANNEL_ONE_OUTPUT = pin[0];
  assign CHANNEL_TWO_OUTPUT = pin[1];

  // helper: count high clocks of channel one over each output period
  logic seg1_q;
  logic seg2_q;
  logic clean_q;
  logic cond_now;
  logic [10:0] hi_cnt_q;
  logic [9:0] ref_q;

  assign cond_now = ctrl_q.sel == DIV_2 && RUN && !fmt_event && active_q[0] < FULL_HIGH_MIN;

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      seg1_q <= 1'b0;
      seg2_q <= 1'b0;
      clean_q <= 1'b0;
      hi_cnt_q <= '0;
      ref_q <= '0;
    end else begin
      seg1_q <= boundary;
      seg2_q <= seg1_q;
      if (seg2_q) begin
        hi_cnt_q <= {10'h000, out_q[0]};
        ref_q <= active_q[0];
        clean_q <= cond_now;
      end else begin
        hi_cnt_q <= hi_cnt_q + {10'h000, out_q[0]};
        clean_q <= clean_q && cond_now;
      end
    end
  end

  // high clocks of channel one per sub-pulse, kept for the last two
  // so neighbours can be compared; only whole divide-by-2 windows count
  logic quarter;
  logic [1:0] qdly_q;
  logic [8:0] sub_cnt_q;
  logic [8:0] sub_prev_q;
  logic [9:0] sub_ref_q;
  logic [9:0] sub_prev_ref_q;
  logic sub_clean_q;
  logic sub_valid_q;

  assign quarter = tick && (phase_q[6:0] == PHASE_LAST[6:0]);

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      qdly_q <= 2'b00;
      sub_cnt_q <= '0;
      sub_prev_q <= '0;
      sub_ref_q <= '0;
      sub_prev_ref_q <= '0;
      sub_clean_q <= 1'b0;
      sub_valid_q <= 1'b0;
    end else begin
      qdly_q <= {qdly_q[0], quarter};
      if (qdly_q[1]) begin
        sub_cnt_q <= {8'h00, out_q[0]};
        sub_prev_q <= sub_cnt_q;
        sub_ref_q <= active_q[0];
        sub_prev_ref_q <= sub_ref_q;
        sub_clean_q <= cond_now;
        sub_valid_q <= sub_clean_q;
      end else begin
        sub_cnt_q <= sub_cnt_q + {8'h00, out_q[0]};
        sub_clean_q <= sub_clean_q && cond_now;
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  ctrl_read_a: assert property (hit_f(req, CTRL_OFS, 1'b0) |=> RDATA[7:3] == 5'b11111)
    else $error("control reserved bits did not read as one");
  duty_read_a: assert property (
    (req.rd && (req.addr == lower_ofs_f(0) || req.addr == upper_ofs_f(1))) |=> RDATA == READ_ALL_ONES)
    else $error("duty byte read was not all ones");
  phase_wrap_a: assert property (boundary |=> phase_q == '0)
    else $error("period did not wrap after 512 slots");
  load_sync_a: assert property (!$stable(active_q[0]) |-> $past(boundary) && $past(pending_q[0]))
    else $error("duty changed away from period boundary");
  lower_only_a: assert property (
    (hit_f(req, lower_ofs_f(0), 1'b1) && !pending_q[0]) |=> !pending_q[0])
    else $error("lower byte write armed a load");
  reset_val_a: assert property ($past(!RSTN) |-> active_q[1] == 10'h000 && ctrl_q.sel == DIV_1)
    else $error("registers not at reset values");
  full_high_a: assert property (
    (RUN && !fmt_event && active_q[0] >= FULL_HIGH_MIN) ##1 RUN |-> CHANNEL_ONE_OUTPUT)
    else $error("output fell with duty fffc or above");
  full_high2_a: assert property (
    (RUN && !fmt_event && active_q[1] >= FULL_HIGH_MIN) ##1 RUN |-> CHANNEL_TWO_OUTPUT)
    else $error("channel two fell with duty fffc or above");
  sub_even_a: assert property (
    (qdly_q[1] && sub_valid_q && sub_clean_q && sub_ref_q == sub_prev_ref_q)
    |-> ({1'b0, sub_cnt_q} <= {1'b0, sub_prev_q} + 10'h001) && ({1'b0, sub_prev_q} <= {1'b0, sub_cnt_q} + 10'h001))
    else $error("sub-pulse high times differ by more than one step");
  status_read_a: assert property (
    hit_f(req, STATUS_OFS, 1'b0) |=> RDATA == {4'h0, $past(out_q), $past(pending_q)})
    else $error("status read did not show pending loads");
  high_time_a: assert property ((seg2_q && clean_q) |-> hi_cnt_q == {1'b0, ref_q} + DUTY_OFFSET)
    else $error("high time per period is not duty plus four");
  event_route_a: assert property ((RUN && fmt_event) |=> out_q[1] == $past(EVENT_PWM[1]))
    else $error("event PWM not routed to channel two");

  load_c: cover property (boundary && pending_q[0]);
  full_c: cover property (seg2_q && clean_q && ref_q == 10'h3fb);
  half_c: cover property (odd_q[0] && !odd_seen_q[0]);
  event_c: cover property (fmt_event && EVENT_PWM[0]);

endmodule

`default_nettype wire

// [rtl/pwm_pkg.sv]
/*
  Shared constants and types for the two-channel pulse-division PWM:
  register offsets, reset values, timebase sizes and the clock-select decode.
  Assumes one 50 MHz system clock and a byte-wide register port.
*/
package pwm_pkg;

  // register offsets on the byte port
  localparam logic [2:0] CTRL_OFS = 3'h0;
  localparam logic [2:0] STATUS_OFS = 3'h1;
  localparam logic [2:0] DUTY_LOWER_OFS = 3'h2;
  localparam logic [2:0] DUTY_UPPER_OFS = 3'h3;
  localparam logic [2:0] DUTY_STRIDE = 3'h2;

  // control field positions
  localparam int SEL_LSB = 0;
  localparam int FMT_BIT = 2;

  // values after reset: duty pair resets to fc00 with the live bits all zero; duty bytes read as ff
  localparam logic [15:0] DUTY_RESET = 16'hfc00;
  localparam logic [7:0] DUTY_LOWER_RESET = DUTY_RESET[7:0];
  localparam logic [1:0] DUTY_UPPER_RESET = DUTY_RESET[9:8];
  localparam logic [7:0] READ_ALL_ONES = 8'hff;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // timebase: 512 input-clock slots per period, four sub-pulses of 128 slots
  localparam int PHASE_BITS = 9;
  localparam logic [8:0] PHASE_LAST = 9'h1ff;
  localparam logic [10:0] DUTY_OFFSET = 11'h004;
  localparam logic [9:0] FULL_HIGH_MIN = 10'h3fc;

  typedef enum logic [1:0] {
    DIV_1 = 2'b00,
    DIV_2 = 2'b01,
    DIV_4 = 2'b10,
    DIV_8 = 2'b11
  } clk_sel_type;

  localparam clk_sel_type CTRL_SEL_RESET = DIV_1;
  localparam logic CTRL_FMT_RESET = 1'b0;

  typedef struct packed {
    logic fmt;
    clk_sel_type sel;
  } ctrl_type;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  // last prescaler count for each clock select
  function automatic logic [2:0] div_last_f(input clk_sel_type sel);
    case (sel)
      DIV_1: div_last_f = 3'h0;
      DIV_2: div_last_f = 3'h1;
      DIV_4: div_last_f = 3'h3;
      DIV_8: div_last_f = 3'h7;
      default: div_last_f = 3'h0;
    endcase
  endfunction

endpackage

// [rtl/pwm_prescaler.sv]
/*
  Prescaler for the PWM input clock: one-cycle enable every 1, 2, 4 or 8
  system clocks, plus a flag for the first half of the current input-clock slot.
  Assumes sel and run come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pwm_prescaler
  import pwm_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire clk_sel_type sel,
  input wire logic run,
  output logic tick,
  output logic first_half
);

  logic [2:0] cnt_q;
  logic [2:0] last;

  assign last = div_last_f(sel);

  // divided input clock
  // >= rather than == so a smaller divider takes effect at once
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= 3'h0;
    end else if (run) begin
      if (cnt_q >= last) begin
        cnt_q <= 3'h0;
      end else begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end

  assign tick = run && (cnt_q >= last);
  assign first_half = cnt_q <= (last >> 1);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  tick_gap_a: assert property ((tick && sel == DIV_8) ##1 (sel == DIV_8) |-> !tick)
    else $error("divide-by-8 enable repeated too soon");
  tick_period_a: assert property (
    (tick && sel == DIV_8 && run) ##1 (sel == DIV_8 && run && !tick) [*7] |=> (tick || sel != DIV_8 || !run))
    else $error("divide-by-8 enable missing after eight clocks");

endmodule

`default_nettype wire

// [verif/pwm_cpu_model.sv]
/*
  CPU side of the pwm byte port: single-cycle byte writes and reads.
  Assumes the system clock and read data one cycle after the strobe.
*/
`timescale 1ns/1ps
`default_nettype none

module pwm_cpu_model
  import pwm_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [2:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  initial begin
    addr = 3'h7;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // idle bus shows the inverse of the last value, never a stale copy
  task automatic release_bus();
    addr <= ~addr;
    wdata <= ~wdata;
  endtask

  task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    release_bus();
  endtask

  task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    release_bus();
    #1 d = rdata;
  endtask

  task automatic write_duty(input logic ch, input logic [9:0] v);
    write_reg(3'(DUTY_LOWER_OFS + ch * DUTY_STRIDE), v[7:0]);
    write_reg(3'(DUTY_UPPER_OFS + ch * DUTY_STRIDE), {6'h3f, v[9:8]});
  endtask
endmodule

`default_nettype wire

// [verif/tb_pulse_division_ten_bit_pwm.sv]
/*
  Self-checking bench for the two-channel pulse-division pwm.
  Assumes a 50 MHz clock; high time is measured in 1 ns samples.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_pulse_division_ten_bit_pwm;
  import pwm_pkg::*;
  logic clk, rstn, wr, rd, run, ch1, ch2, moved;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [1:0] event_pwm, o;
  int err_count, checks, h1, h2, e1, e2;
  logic [9:0] d1_t [4] = '{10'h000, 10'h03c, 10'h23c, 10'h3f0};
  logic [9:0] d2_t [4] = '{10'h3ff, 10'h3fc, 10'h001, 10'h002};

  pwm_cpu_model cpu (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  pulse_division_ten_bit_pwm #(.HAS_FORMAT_SELECT(1'b1)) dut (
    .CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .RUN(run), .EVENT_PWM(event_pwm), .CHANNEL_ONE_OUTPUT(ch1), .CHANNEL_TWO_OUTPUT(ch2));

  initial clk = 1'b0;
  always #10 clk = ~clk;

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    cpu.read_reg(a, d);
    check("rdata", {24'h0, exp}, {24'h0, d});
  endtask

  // one period window: any alignment sees the whole high time
  task automatic measure(input int s);
    logic p1, p2;
    h1 = 0; h2 = 0; e1 = 0; e2 = 0;
    @(posedge clk);
    #0.5;
    p1 = ch1;
    p2 = ch2;
    repeat (10240 << s) begin
      #1;
      h1 += int'(ch1 === 1'b1);
      h2 += int'(ch2 === 1'b1);
      e1 += int'(ch1 === 1'b1 && p1 === 1'b0);
      e2 += int'(ch2 === 1'b1 && p2 === 1'b0);
      p1 = ch1;
      p2 = ch2;
    end
  endtask

  function automatic int exp_h(input int s, input logic [9:0] v);
    return (v >= FULL_HIGH_MIN) ? (10240 << s) : ((int'(v) + 4) * (10 << s));
  endfunction

  function automatic int exp_e(input logic [9:0] v);
    return (v >= FULL_HIGH_MIN) ? 0 : 4;
  endfunction

  initial begin
    #1000000;
    err_count++;
    end_of_test();
  end

  initial begin
    rstn = 1'b0;
    run = 1'b1;
    event_pwm = 2'b00;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    measure(0);
    check("reset high ch1", 40, h1);
    check("reset high ch2", 40, h2);
    rd_chk(CTRL_OFS, 8'hf8);
    rd_chk(DUTY_LOWER_OFS, READ_ALL_ONES);
    rd_chk(3'h5, READ_ALL_ONES);
    rd_chk(3'h6, READ_UNMAPPED);
    cpu.write_reg(CTRL_OFS, 8'h03);
    rd_chk(CTRL_OFS, 8'hfb);
    cpu.write_reg(CTRL_OFS, 8'hff);
    rd_chk(CTRL_OFS, 8'hff);
    for (int i = 1; i < 3; i++) begin
      @(posedge clk);
      event_pwm <= i[1:0];
      repeat (3) @(negedge clk);
      check("event ch1", i[0], ch1);
      check("event ch2", i[1], ch2);
    end
    for (int s = 0; s < 4; s++) begin
      cpu.write_reg(CTRL_OFS, 8'(s));
      cpu.write_duty(1'b0, d1_t[s]);
      cpu.write_duty(1'b1, d2_t[s]);
      repeat (2 * (512 << s)) @(posedge clk);
      measure(s);
      check("high ch1", exp_h(s, d1_t[s]), h1);
      check("high ch2", exp_h(s, d2_t[s]), h2);
      check("pulses ch1", exp_e(d1_t[s]), e1);
      check("pulses ch2", exp_e(d2_t[s]), e2);
    end
    // a lone lower byte must not reach the waveform
    cpu.write_reg(DUTY_LOWER_OFS, 8'h00);
    repeat (8192) @(posedge clk);
    measure(3);
    check("lower only", exp_h(3, 10'h3f0), h1);
    @(posedge clk);
    run <= 1'b0;
    cpu.write_duty(1'b1, 10'h100);
    cpu.read_reg(STATUS_OFS, d);
    check("pending ch2", 1, d[1]);
    o = {ch1, ch2};
    moved = 1'b0;
    repeat (600) begin
      @(negedge clk);
      moved = moved | ({ch1, ch2} !== o);
    end
    check("frozen", 0, moved);
    end_of_test();
  end
endmodule

`default_nettype wire
